/* rtl/ssbm_device.sv */
/*
  Device end: bandgap mismatch supervision and the comparator self-test
  sequencer with its four result words.
  Assumes the analog side reports mismatch percent and comparator levels
  synchronous to clk, and answers a forced test level within
  TOGGLE_WAIT_CYC cycles.
*/
// Overview of operation
// R1: 4 to 12 percent mismatch is critical
// R2: critical mismatch keeps switchers from starting
// R3: mismatch at power-up fails test, blocks
// R4: running, bypass 0: drift shuts power stages
// R5: running, bypass 1: drift only interrupts
// R6: bandgap fault flag set unless masked
// R7: fault state tracks present mismatch
// R8: self-test exercises every OV and UV comparator
// R9: non-toggling comparator sets rail warning bit
// R10: four result words, one bit per rail
// R11: each run overwrites all result words
// R12: secure mode rejects ordinary result clears
// R13: power-up continues whatever the results
// R14: run request starts test, self-clears
// R15: host uses secure write to run
// R16: on-demand blanking at most 200 us
// R17: host ensures safe state before run
// R18: on-demand failures set result flags
// R19: host checks results after each run
// R20: run request ignored while busy
// R21: fault flag sticky until host clears
`timescale 1ns/1ns
`default_nettype none
module ssbm_device
(
  input  wire logic                            clk,
  input  wire logic                            reset_n,
  input  wire logic                            clk_en,
  ssbm_if.device                               bus,
  input  wire logic [7:0]                      mismatch_pct,
  input  wire logic                            bandgap_monitor_bypass,
  input  wire logic                            secure_write_enable,
  input  wire logic                            powerup_request,
  input  wire logic                            system_on,
  input  wire logic [ssbm_pkg::NUM_COMP-1:0]   comparator_level,
  output logic      [ssbm_pkg::NUM_COMP-1:0]   comparator_force,
  output logic                                 monitor_blank,
  output logic                                 regulator_start_enable,
  output logic                                 power_stage_shutdown,
  output logic                                 powerup_selftest_fail,
  output logic                                 powerup_done
);
  import ssbm_pkg::*;

  // ****************
  // bandgap supervision
  // ****************
  logic        critical;
  logic        state_reg;
  logic        irq_reg;
  logic        shutdown_reg;
  logic        pu_fail_reg;
  logic        pu_done_reg;
  logic        on_demand_reg;
  ssbm_state_t state_reg_fsm;

  assign critical = (mismatch_pct >= MISMATCH_MIN_PCT)
                 && (mismatch_pct <= MISMATCH_MAX_PCT); // [R1]

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg <= critical; // [R7]
    end
  end

  logic irq_clear;
  assign irq_clear = bus.cmd_valid && (bus.cmd_op == SSBM_OP_IRQ_CLR);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_reg <= 1'b0;
    end else if (clk_en) begin
      // set wins over a clear in the same cycle
      if (critical && !bus.irq_mask) begin
        irq_reg <= 1'b1; // [R6]
      end else if (irq_clear) begin
        irq_reg <= 1'b0; // [R21]
      end
    end
  end

  // shutdown latches: stages stay off until reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shutdown_reg <= 1'b0;
    end else if (clk_en && system_on && critical && !bandgap_monitor_bypass) begin
      shutdown_reg <= 1'b1; // [R4] [R5]
    end
  end

  // ****************
  // self-test sequencer
  // ****************
  logic [NUM_COMP-1:0] fail_reg;
  logic [NUM_COMP-1:0] base_reg;
  logic [15:0]         wait_reg;
  logic [17:0]         blank_cnt_reg;
  logic                run_req;
  logic                res_clear;

  assign run_req = bus.cmd_valid && (bus.cmd_op == SSBM_OP_RUN)
                && (bus.cmd_secure || !secure_write_enable)
                && system_on && (state_reg_fsm == SSBM_ST_IDLE); // [R20]
  assign res_clear = bus.cmd_valid && (bus.cmd_op == SSBM_OP_CLEAR)
                  && (bus.cmd_secure || !secure_write_enable); // [R12]

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg_fsm <= SSBM_ST_IDLE;
      on_demand_reg <= 1'b0;
      wait_reg      <= 16'h0000;
      base_reg      <= '0;
    end else if (clk_en) begin
      unique case (state_reg_fsm)
        SSBM_ST_IDLE: begin
          if (powerup_request && !pu_done_reg && !pu_fail_reg) begin
            on_demand_reg <= 1'b0;
            base_reg      <= comparator_level;
            wait_reg      <= 16'h0000;
            state_reg_fsm <= SSBM_ST_FORCE;
          end else if (run_req) begin
            on_demand_reg <= 1'b1; // [R14]
            base_reg      <= comparator_level;
            wait_reg      <= 16'h0000;
            state_reg_fsm <= SSBM_ST_FORCE;
          end
        end
        SSBM_ST_FORCE: begin
          wait_reg <= wait_reg + 16'h0001;
          if (wait_reg == 16'(TOGGLE_WAIT_CYC - 1)) begin
            state_reg_fsm <= SSBM_ST_CHECK;
          end
        end
        SSBM_ST_CHECK: begin
          state_reg_fsm <= SSBM_ST_DONE;
        end
        SSBM_ST_DONE: begin
          state_reg_fsm <= SSBM_ST_IDLE;
        end
      endcase
    end
  end

  // every comparator driven to the opposite level at once
  assign comparator_force = (state_reg_fsm == SSBM_ST_FORCE
                          || state_reg_fsm == SSBM_ST_CHECK) ? ~base_reg : '0; // [R8]

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fail_reg <= {LINEAR_RES_RST, BUCK_RES_RST, LINEAR_RES_RST, BUCK_RES_RST};
    end else if (clk_en) begin
      if (state_reg_fsm == SSBM_ST_CHECK) begin
        fail_reg <= ~(comparator_level ^ base_reg); // [R9] [R11] [R18]
      end else if (res_clear && state_reg_fsm == SSBM_ST_IDLE) begin
        fail_reg <= '0; // [R12]
      end
    end
  end

  // result words: buck OV, linear OV, buck UV, linear UV
  assign bus.buck_ov_res   = fail_reg[NUM_BUCK-1:0]; // [R10]
  assign bus.linear_ov_res = fail_reg[NUM_BUCK+NUM_LINEAR-1:NUM_BUCK];
  assign bus.buck_uv_res   = fail_reg[2*NUM_BUCK+NUM_LINEAR-1:NUM_BUCK+NUM_LINEAR];
  assign bus.linear_uv_res = fail_reg[NUM_COMP-1:2*NUM_BUCK+NUM_LINEAR];

  // blanking guard: the sequence is far shorter, counter only proves the ceiling
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      blank_cnt_reg <= 18'h00000;
    end else if (clk_en) begin
      if (state_reg_fsm == SSBM_ST_IDLE) begin
        blank_cnt_reg <= 18'h00000;
      end else if (blank_cnt_reg != 18'(BLANK_MAX_CYC)) begin
        blank_cnt_reg <= blank_cnt_reg + 18'h00001;
      end
    end
  end
  assign monitor_blank = on_demand_reg && (state_reg_fsm != SSBM_ST_IDLE)
                      && (blank_cnt_reg != 18'(BLANK_MAX_CYC)); // [R16]

  // ****************
  // power-up outcome
  // ****************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pu_fail_reg <= 1'b0;
      pu_done_reg <= 1'b0;
    end else if (clk_en) begin
      if (!on_demand_reg && state_reg_fsm != SSBM_ST_IDLE && critical) begin
        pu_fail_reg <= 1'b1; // [R3]
      end
      if (!on_demand_reg && state_reg_fsm == SSBM_ST_DONE && !critical && !pu_fail_reg) begin
        pu_done_reg <= 1'b1; // [R13]
      end
    end
  end

  assign regulator_start_enable = pu_done_reg && !critical && !pu_fail_reg; // [R2]
  assign power_stage_shutdown   = shutdown_reg;
  assign powerup_selftest_fail  = pu_fail_reg;
  assign powerup_done           = pu_done_reg;
  assign bus.run_busy           = (state_reg_fsm != SSBM_ST_IDLE) && on_demand_reg; // [R14]
  assign bus.irq_flag           = irq_reg;
  assign bus.fault_state        = state_reg;
endmodule
`default_nettype wire

/* inc/ssbm_pkg.sv */
/*
  Package for the safety supervision block: bandgap monitor and analog
  comparator self-test. Shared by the device end and the host end.
  Assumes one 250 MHz control clock on both ends.
*/
`default_nettype none
package ssbm_pkg;
  // ****************
  // sizes
  // ****************
  localparam int NUM_BUCK   = 7;
  localparam int NUM_LINEAR = 4;
  localparam int NUM_COMP   = 2 * (NUM_BUCK + NUM_LINEAR);
  // ****************
  // mismatch window, percent
  // ****************
  localparam logic [7:0] MISMATCH_MIN_PCT = 8'h04;
  localparam logic [7:0] MISMATCH_MAX_PCT = 8'h0C;
  // ****************
  // timing
  // ****************
  localparam int CLK_PERIOD_NS   = 4;
  localparam int BLANK_MAX_US    = 200;
  localparam int BLANK_MAX_CYC   = (BLANK_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int TOGGLE_WAIT_CYC = 4;
  // ****************
  // reset values
  // ****************
  localparam logic [NUM_BUCK-1:0]   BUCK_RES_RST   = 7'h00;
  localparam logic [NUM_LINEAR-1:0] LINEAR_RES_RST = 4'h0;

  typedef enum logic [1:0] {
    SSBM_ST_IDLE  = 2'b00,
    SSBM_ST_FORCE = 2'b01,
    SSBM_ST_CHECK = 2'b10,
    SSBM_ST_DONE  = 2'b11
  } ssbm_state_t;

  typedef enum logic [1:0] {
    SSBM_OP_NONE     = 2'b00,
    SSBM_OP_RUN      = 2'b01,
    SSBM_OP_CLEAR    = 2'b10,
    SSBM_OP_IRQ_CLR  = 2'b11
  } ssbm_op_t;
endpackage
`default_nettype wire

/* inc/ssbm_if.sv */
/*
  Interface joining host and device ends: a simple command strobe with a
  secure qualifier, and the device's result and status words.
  Assumes both ends share clk.
*/
`timescale 1ns/1ns
`default_nettype none
interface ssbm_if;
  import ssbm_pkg::*;
  logic                  cmd_valid;
  ssbm_op_t              cmd_op;
  logic                  cmd_secure;
  logic                  irq_mask;
  logic                  run_busy;
  logic                  irq_flag;
  logic                  fault_state;
  logic [NUM_BUCK-1:0]   buck_ov_res;
  logic [NUM_LINEAR-1:0] linear_ov_res;
  logic [NUM_BUCK-1:0]   buck_uv_res;
  logic [NUM_LINEAR-1:0] linear_uv_res;
  modport device (input cmd_valid, cmd_op, cmd_secure, irq_mask,
                  output run_busy, irq_flag, fault_state,
                  buck_ov_res, linear_ov_res, buck_uv_res, linear_uv_res);
  modport host   (output cmd_valid, cmd_op, cmd_secure, irq_mask,
                  input run_busy, irq_flag, fault_state,
                  buck_ov_res, linear_ov_res, buck_uv_res, linear_uv_res);
endinterface
`default_nettype wire

/* rtl/ssbm_host.sv */
/*
  Host end: turns user requests into one-cycle commands, always using the
  secure qualifier when secure writes are enabled, and reports results.
  Assumes the user holds safe state before asking for a run.
*/
`timescale 1ns/1ns
`default_nettype none
module ssbm_host
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  ssbm_if.host            bus,
  input  wire logic       secure_mode,
  input  wire logic       user_run,
  input  wire logic       user_system_safe,
  input  wire logic       user_clear,
  input  wire logic       user_irq_clear,
  input  wire logic       user_irq_mask,
  output logic            user_busy,
  output logic            user_any_fail,
  output logic            user_result_valid
);
  import ssbm_pkg::*;

  logic     valid_reg;
  ssbm_op_t op_reg;
  logic     busy_seen_reg;
  logic     fail_reg;
  logic     res_valid_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      valid_reg <= 1'b0;
      op_reg    <= SSBM_OP_NONE;
    end else if (clk_en) begin
      valid_reg <= 1'b0;
      op_reg    <= SSBM_OP_NONE;
      // run only from a safe system, never over an on-demand run in progress
      if (user_run && user_system_safe && !bus.run_busy && !busy_seen_reg) begin // [R17] [R20]
        valid_reg <= 1'b1;
        op_reg    <= SSBM_OP_RUN;
      end else if (user_clear) begin
        valid_reg <= 1'b1;
        op_reg    <= SSBM_OP_CLEAR;
      end else if (user_irq_clear) begin
        valid_reg <= 1'b1;
        op_reg    <= SSBM_OP_IRQ_CLR;
      end
    end
  end

  assign bus.cmd_valid  = valid_reg;
  assign bus.cmd_op     = op_reg;
  assign bus.cmd_secure = secure_mode; // [R15] [R12]
  assign bus.irq_mask   = user_irq_mask;

  // result check after each run end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_seen_reg <= 1'b0;
      fail_reg      <= 1'b0;
      res_valid_reg <= 1'b0;
    end else if (clk_en) begin
      if (valid_reg && op_reg == SSBM_OP_RUN) begin
        busy_seen_reg <= 1'b1;
        res_valid_reg <= 1'b0;
      end else if (busy_seen_reg && !bus.run_busy) begin
        busy_seen_reg <= 1'b0;
        res_valid_reg <= 1'b1;
        fail_reg      <= (|bus.buck_ov_res) | (|bus.linear_ov_res)
                       | (|bus.buck_uv_res) | (|bus.linear_uv_res); // [R19]
      end
    end
  end

  assign user_busy         = busy_seen_reg || bus.run_busy;
  assign user_any_fail     = fail_reg;
  assign user_result_valid = res_valid_reg;
endmodule
`default_nettype wire

/* verif/ssbm_assertions.sv */
/*
  Checker for the host/device link of the safety supervision block.
  Assumes the test top feeds it the link signals and the shared clock.
*/
`timescale 1ns/1ns
`default_nettype none
module ssbm_assertions
(
  input wire logic                          clk,
  input wire logic                          reset_n,
  input wire logic                          cmd_valid,
  input wire ssbm_pkg::ssbm_op_t            cmd_op,
  input wire logic                          cmd_secure,
  input wire logic                          irq_mask,
  input wire logic                          run_busy,
  input wire logic                          irq_flag,
  input wire logic                          fault_state,
  input wire logic [ssbm_pkg::NUM_BUCK-1:0]   buck_ov_res,
  input wire logic [ssbm_pkg::NUM_LINEAR-1:0] linear_ov_res,
  input wire logic [ssbm_pkg::NUM_BUCK-1:0]   buck_uv_res,
  input wire logic [ssbm_pkg::NUM_LINEAR-1:0] linear_uv_res
);
  import ssbm_pkg::*;
  // ************
  // properties
  // ************
  wire [21:0] res = {linear_uv_res, buck_uv_res, linear_ov_res, buck_ov_res};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_busy_cause: assert property ($rose(run_busy) |-> $past(cmd_valid && cmd_op == SSBM_OP_RUN))
    else $error("busy without run command");
  a_busy_span: assert property ($rose(run_busy) |-> run_busy [*6] ##1 !run_busy)
    else $error("busy span not six cycles");
  a_res_steady: assert property ($rose(run_busy) |-> $stable(res) [*5])
    else $error("results moved before run end");
  a_clear_zero: assert property (cmd_valid && cmd_op == SSBM_OP_CLEAR && cmd_secure
    && !run_busy |=> res == 22'h000000) else $error("secure clear ignored");
  a_irq_clear: assert property (cmd_valid && cmd_op == SSBM_OP_IRQ_CLR && irq_mask |=> !irq_flag)
    else $error("flag clear ignored");
  a_irq_hold: assert property (irq_flag && !(cmd_valid && cmd_op == SSBM_OP_IRQ_CLR) |=> irq_flag)
    else $error("flag dropped by itself");
  a_irq_unmasked: assert property ($rose(irq_flag) |-> !$past(irq_mask))
    else $error("flag set while masked");
  a_irq_fault: assert property ($rose(irq_flag) |-> fault_state)
    else $error("flag set without fault");
endmodule
`default_nettype wire

/* verif/test_safety_selftest_bandgap_monitor.sv */
/*
  Bench: host and device joined by one link, a second device driven by the
  bench to break host rules. Assumes ssbm_pkg and ssbm_if are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module test_safety_selftest_bandgap_monitor;
  import ssbm_pkg::*;
  // ************
  // wiring
  // ************
  logic        clk, reset_n, bypass, sec, pu_req, son, run, clr, iclr, mask;
  logic [7:0]  pct;
  logic [21:0] stuck, f1, f2;
  logic        blank, rse, shut, pfail, ufail, pdone, ubusy, uvalid, safe;
  int          fail_count = 0, n_checks = 0, i, n, b;
  logic [22:0] rows [6] = '{23'h7FFFFF, 23'h000000, 23'h40007F, 23'h400780, 23'h43F800, 23'h7C0000};
  logic [7:0]  pcts [4] = '{8'h03, 8'h04, 8'h0C, 8'h0D};
  ssbm_if bus_if();
  ssbm_if bad_if();
  wire [21:0] res = {bus_if.linear_uv_res, bus_if.buck_uv_res, bus_if.linear_ov_res, bus_if.buck_ov_res};
  wire [21:0] res2 = {bad_if.linear_uv_res, bad_if.buck_uv_res, bad_if.linear_ov_res, bad_if.buck_ov_res};
  ssbm_device ssbm_device_i (.clk(clk), .reset_n(reset_n), .clk_en(1'b1), .bus(bus_if.device),
    .mismatch_pct(pct), .bandgap_monitor_bypass(bypass), .secure_write_enable(sec),
    .powerup_request(pu_req), .system_on(son), .comparator_level(f1 ^ stuck),
    .comparator_force(f1), .monitor_blank(blank), .regulator_start_enable(rse),
    .power_stage_shutdown(shut), .powerup_selftest_fail(pfail), .powerup_done(pdone));
  // second device always in secure mode, commanded straight from the bench
  ssbm_device ssbm_device_i2 (.clk(clk), .reset_n(reset_n), .clk_en(1'b1), .bus(bad_if.device),
    .mismatch_pct(pct), .bandgap_monitor_bypass(bypass), .secure_write_enable(1'b1),
    .powerup_request(pu_req), .system_on(son), .comparator_level(f2 ^ stuck),
    .comparator_force(f2), .monitor_blank(), .regulator_start_enable(),
    .power_stage_shutdown(), .powerup_selftest_fail(), .powerup_done());
  ssbm_host ssbm_host_i (.clk(clk), .reset_n(reset_n), .clk_en(1'b1), .bus(bus_if.host),
    .secure_mode(sec), .user_run(run), .user_system_safe(safe), .user_clear(clr),
    .user_irq_clear(iclr), .user_irq_mask(mask), .user_busy(ubusy), .user_any_fail(ufail),
    .user_result_valid(uvalid));
  ssbm_assertions ssbm_assertions_i (.clk(clk), .reset_n(reset_n), .cmd_valid(bus_if.cmd_valid),
    .cmd_op(bus_if.cmd_op), .cmd_secure(bus_if.cmd_secure), .irq_mask(bus_if.irq_mask),
    .run_busy(bus_if.run_busy), .irq_flag(bus_if.irq_flag), .fault_state(bus_if.fault_state),
    .buck_ov_res(bus_if.buck_ov_res), .linear_ov_res(bus_if.linear_ov_res),
    .buck_uv_res(bus_if.buck_uv_res), .linear_uv_res(bus_if.linear_uv_res));
  // ************
  // tasks
  // ************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h", $time, m, got);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask
  // fixed window, long enough for the six cycle run plus host latency
  task automatic span(output int nb, output int nr);
    nb = 0;
    nr = 0;
    for (int k = 0; k < 40; k++) begin
      @(negedge clk);
      nb += blank;
      // only one of the two busy views is active in any one scenario
      nr += bad_if.run_busy + ubusy;
    end
  endtask
  task automatic bad_cmd(input ssbm_op_t op, input logic s);
    bad_if.cmd_valid = 1'b1;
    bad_if.cmd_op = op;
    bad_if.cmd_secure = s;
    @(negedge clk);
    bad_if.cmd_valid = 1'b0;
    // an edge passes before a next call may raise the strobe again
    @(negedge clk);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ************
  // sequence
  // ************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    {reset_n, pct, sec, run, clr, iclr, mask} = '0;
    {bypass, pu_req, son} = 3'h7;
    stuck = 22'h0000F0;
    bad_if.cmd_valid = 1'b0;
    bad_if.cmd_op = SSBM_OP_NONE;
    bad_if.cmd_secure = 1'b0;
    bad_if.irq_mask = 1'b0;
    safe = 1'b1;
    tick(2);
    reset_n = 1'b1;
    tick(30);
    chk(rse, 1, "start after failed test");
    chk(res, 22'h0000F0, "power-up results");
    chk(pdone, 1, "power-up done");
    for (i = 0; i < 6; i++) begin
      stuck = rows[i][21:0];
      run = 1'b1;
      tick(1);
      run = 1'b0;
      span(n, b);
      chk(res, stuck, "run results");
      chk(n, 6, "blank cycles");
      chk(bus_if.run_busy, 0, "run bit clear");
      chk(ufail, rows[i][22], "any fail");
      chk(uvalid, 1, "result valid");
      // six run cycles plus one for the host to see the run end
      chk(b, 7, "host busy cycles");
    end
    // unsafe system: the host must hold the run back
    safe = 1'b0;
    run = 1'b1;
    tick(1);
    run = 1'b0;
    span(n, b);
    chk(n + b, 0, "run while unsafe");
    safe = 1'b1;
    $display("selftest table done");
    sec = 1'b1;
    stuck = 22'h000001;
    bad_cmd(SSBM_OP_RUN, 1'b0);
    bad_cmd(SSBM_OP_CLEAR, 1'b0);
    span(n, b);
    chk(res2, 22'h0000F0, "insecure ops");
    bad_cmd(SSBM_OP_RUN, 1'b1);
    bad_cmd(SSBM_OP_RUN, 1'b1);
    span(n, b);
    // four of the six busy cycles pass inside the two calls
    chk(b + 4, 6, "run during busy");
    chk(res2, stuck, "secure run");
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
    tick(6);
    chk(res, 22'h000000, "secure clear");
    $display("secure test done");
    for (i = 0; i < 4; i++) begin
      pct = pcts[i];
      tick(3);
      n = (pct >= MISMATCH_MIN_PCT && pct <= MISMATCH_MAX_PCT);
      chk(bus_if.fault_state, n, "fault state");
      chk(rse, !n, "start block");
    end
    chk(shut, 0, "bypass shutdown");
    chk(bus_if.irq_flag, 1, "fault flag");
    mask = 1'b1;
    iclr = 1'b1;
    tick(1);
    iclr = 1'b0;
    pct = 8'h08;
    tick(3);
    chk(bus_if.irq_flag, 0, "masked flag");
    son = 1'b0;
    bypass = 1'b0;
    tick(3);
    chk(shut, 0, "shutdown while off");
    son = 1'b1;
    tick(3);
    chk(shut, 1, "drift shutdown");
    $display("bandgap test done");
    bypass = 1'b1;
    reset_n = 1'b0;
    tick(2);
    reset_n = 1'b1;
    tick(30);
    chk(pfail, 1, "power-up fail");
    chk(rse, 0, "power-up blocked");
    $display("power-up test done");
    finish_test();
  end
endmodule
`default_nettype wire
